// *** rtl/external_interrupt_latch.sv ***
// Purpose: External interrupt latch with a dedicated active-low pin and a port pin group
// Assumes: Core pulses instrEnd once per instruction; pins are asynchronous to clock
// Notes:   Registers over AXI4-Lite; one write and one read outstanding at most
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`include "ext_int_defines.svh"

module external_interrupt_latch
  import ext_int_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst_n,
  input  wire axi_lite_req_t axiReq,
  output axi_lite_rsp_t      axiRsp,
  input  wire cpu_ctl_t      cpuCtl,
  output cpu_int_t           cpuInt,
  input  wire logic          irqPin_n,
  input  wire logic [3:0]    portIntPins
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rstMeta_n;
  logic rstSync_n;

  // Assert at once, release two edges later so no flop sees a runt release
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_n <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_n <= 1'b1;
      rstSync_n <= rstMeta_n;
    end
  end

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic reg_sel_t regSel(input logic [31:0] addr);
    reg_sel_t sel;
    sel = SEL_NONE;
    if (addr[7:0] == `EXT_INT_SC_OFFSET) begin
      sel = SEL_SC;
    end else if (addr[7:0] == `EXT_INT_OPT_OFFSET) begin
      sel = SEL_OPT;
    end
    return sel;
  endfunction

  // ----------------------------------------------------------------------
  // State and reset image
  // ----------------------------------------------------------------------
  localparam state_t ST_RST = '{
    irqMeta:    `EXT_INT_IRQ_IDLE,
    irqSync:    `EXT_INT_IRQ_IDLE,
    irqPrev:    `EXT_INT_IRQ_IDLE,
    portMeta:   `EXT_INT_PORT_IDLE,
    portSync:   `EXT_INT_PORT_IDLE,
    portPrev:   `EXT_INT_PORT_IDLE,
    latch:      `EXT_INT_PEND_RST,
    enable:     `EXT_INT_EN_RST,
    mask:       `EXT_INT_MASK_RST,
    portSel:    `EXT_INT_PSEL_RST,
    levelSense: `EXT_INT_LVL_RST,
    phase:      PH_IDLE,
    cpu:        '0,
    axi:        '0
  };

  state_t   st_r;
  state_t   st_nxt;
  logic     wrFire;
  logic     rdFire;
  reg_sel_t wrSel;
  reg_sel_t rdSel;
  logic     scWrite;
  logic     clrHit;
  logic     dedSet;
  logic     portSet;
  logic     reqSet;
  logic     takeNow;
  logic     lowPower;

  // ----------------------------------------------------------------------
  // Request detection
  // ----------------------------------------------------------------------
  // Only the second and third stages are looked at; the first stays private
  assign dedSet  = (st_r.irqPrev & ~st_r.irqSync)
                 | (st_r.levelSense & ~st_r.irqSync);
  // Per-pin edges, so a pin must fall back before it can request again
  assign portSet = st_r.portSel
                 & ((|(st_r.portSync & ~st_r.portPrev))
                 | (st_r.levelSense & (|st_r.portSync)));
  assign reqSet  = dedSet | portSet;

  // Enable gates service, not capture, so a disabled request stays visible
  assign takeNow = (st_r.phase == PH_IDLE) & cpuCtl.instrEnd & st_r.latch
                 & ~st_r.mask & st_r.enable;
  assign lowPower = cpuCtl.stopExec | cpuCtl.waitExec;

  // ----------------------------------------------------------------------
  // Bus strobes
  // ----------------------------------------------------------------------
  assign wrFire  = st_r.axi.awready & axiReq.awvalid & axiReq.wvalid;
  assign rdFire  = st_r.axi.arready & axiReq.arvalid;
  assign wrSel   = regSel(axiReq.awaddr);
  assign rdSel   = regSel(axiReq.araddr);
  assign scWrite = wrFire & (wrSel == SEL_SC) & axiReq.wstrb[0];
  assign clrHit  = scWrite & axiReq.wdata[`EXT_INT_CLR_BIT];

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // Two-stage synchronisers plus a history stage for edges
    st_nxt.irqMeta  = irqPin_n;
    st_nxt.irqSync  = st_r.irqMeta;
    st_nxt.irqPrev  = st_r.irqSync;
    st_nxt.portMeta = portIntPins;
    st_nxt.portSync = st_r.portMeta;
    st_nxt.portPrev = st_r.portSync;
    // Branch-on-pin sees the dedicated pin alone
    st_nxt.cpu.pinLevel = st_r.irqSync;
    st_nxt.cpu.intStart = 1'b0;

    // Latch: a new request wins over any clear in the same cycle
    if (reqSet) begin
      st_nxt.latch = 1'b1;
    end else if (clrHit || st_r.phase == PH_VEC_HI) begin
      st_nxt.latch = 1'b0;
    end

    // Enable: software writes it, low-power entry forces it on
    if (scWrite) begin
      st_nxt.enable = axiReq.wdata[`EXT_INT_EN_BIT];
    end
    if (lowPower) begin
      st_nxt.enable = 1'b1;
    end

    // Option bits are written only through the option register and read back from it
    if (wrFire && wrSel == SEL_OPT && axiReq.wstrb[0]) begin
      st_nxt.portSel    = axiReq.wdata[`EXT_INT_PSEL_BIT];
      st_nxt.levelSense = axiReq.wdata[`EXT_INT_LVL_BIT];
    end

    // Mask bit: core set/clear, low-power entry clears, service entry sets
    if (cpuCtl.setMask) begin
      st_nxt.mask = 1'b1;
    end
    if (cpuCtl.clearMask || lowPower) begin
      st_nxt.mask = 1'b0;
    end
    if (takeNow) begin
      st_nxt.mask = 1'b1;
    end

    // Vector sequence: high byte address, then low byte address
    unique case (st_r.phase)
      PH_IDLE: begin
        st_nxt.cpu.vecFetch = 1'b0;
        if (takeNow) begin
          st_nxt.phase        = PH_VEC_HI;
          st_nxt.cpu.intStart = 1'b1;
          st_nxt.cpu.vecFetch = 1'b1;
          st_nxt.cpu.vecAddr  = `EXT_INT_VEC_HI;
        end
      end
      PH_VEC_HI: begin
        st_nxt.phase       = PH_VEC_LO;
        st_nxt.cpu.vecAddr = `EXT_INT_VEC_LO;
      end
      PH_VEC_LO: begin
        st_nxt.phase        = PH_IDLE;
        st_nxt.cpu.vecFetch = 1'b0;
      end
      default: begin
        st_nxt.phase        = PH_IDLE;
        st_nxt.cpu.vecFetch = 1'b0;
      end
    endcase
    st_nxt.cpu.maskBit = st_nxt.mask;

    // Write channel: take address and data together, answer one cycle on
    st_nxt.axi.awready = 1'b0;
    st_nxt.axi.wready  = 1'b0;
    if (wrFire) begin
      st_nxt.axi.bvalid = 1'b1;
      st_nxt.axi.bresp  = (wrSel == SEL_NONE) ? `EXT_INT_RESP_SLVERR : `EXT_INT_RESP_OKAY;
    end else if (st_r.axi.bvalid && axiReq.bready) begin
      st_nxt.axi.bvalid = 1'b0;
    end
    if (!st_r.axi.bvalid && !st_r.axi.awready && axiReq.awvalid && axiReq.wvalid) begin
      st_nxt.axi.awready = 1'b1;
      st_nxt.axi.wready  = 1'b1;
    end

    // Read channel: pending flag is live latch, clear bit reads as zero
    st_nxt.axi.arready = 1'b0;
    if (rdFire) begin
      st_nxt.axi.rvalid = 1'b1;
      st_nxt.axi.rdata  = 32'h0000_0000;
      st_nxt.axi.rresp  = `EXT_INT_RESP_OKAY;
      unique case (rdSel)
        SEL_SC: begin
          st_nxt.axi.rdata[`EXT_INT_EN_BIT]   = st_r.enable;
          st_nxt.axi.rdata[`EXT_INT_PEND_BIT] = st_r.latch;
        end
        SEL_OPT: begin
          st_nxt.axi.rdata[`EXT_INT_PSEL_BIT] = st_r.portSel;
          st_nxt.axi.rdata[`EXT_INT_LVL_BIT]  = st_r.levelSense;
        end
        SEL_NONE: begin
          st_nxt.axi.rresp = `EXT_INT_RESP_SLVERR;
        end
        default: begin
          st_nxt.axi.rresp = `EXT_INT_RESP_SLVERR;
        end
      endcase
    end else if (st_r.axi.rvalid && axiReq.rready) begin
      st_nxt.axi.rvalid = 1'b0;
    end
    if (!st_r.axi.rvalid && !st_r.axi.arready && axiReq.arvalid) begin
      st_nxt.axi.arready = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Reset image clears pending, sets enable and mask
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign axiRsp = st_r.axi;
  assign cpuInt = st_r.cpu;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cbAssert @(posedge clock);
  endclocking
  default disable iff (!rstSync_n);

  property p_take_gate;
    st_r.cpu.intStart |-> $past(st_r.latch && st_r.enable && !st_r.mask && cpuCtl.instrEnd);
  endproperty
  a_take_gate: assert property (p_take_gate) else $error("service began without cause");

  property p_vec_seq;
    st_r.cpu.intStart |-> (st_r.cpu.vecFetch && st_r.cpu.vecAddr == 16'h07fa)
      ##1 (st_r.cpu.vecFetch && st_r.cpu.vecAddr == 16'h07fb) ##1 !st_r.cpu.vecFetch;
  endproperty
  a_vec_seq: assert property (p_vec_seq) else $error("vector fetch order wrong");

  property p_fetch_clear;
    (st_r.phase == PH_VEC_HI && !reqSet) |=> !st_r.latch;
  endproperty
  a_fetch_clear: assert property (p_fetch_clear) else $error("latch kept over fetch");

  property p_mask_block;
    (st_r.mask && !cpuCtl.clearMask && !lowPower) |=> ##1 !st_r.cpu.intStart;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked request serviced");

  property p_sw_clear;
    (clrHit && !reqSet && st_r.phase != PH_VEC_HI) |=> !st_r.latch;
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("clear bit ignored");

  property p_level_hold;
    (st_r.levelSense && !st_r.irqSync) |=> st_r.latch;
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("low level not latched");

  property p_edge_only;
    (!st_r.levelSense && st_r.irqPrev && !st_r.irqSync) |=> st_r.latch;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("falling edge missed");

  property p_port_level;
    (st_r.portSel && st_r.levelSense && (|st_r.portSync)) |=> st_r.latch;
  endproperty
  a_port_level: assert property (p_port_level) else $error("port level not latched");

  property p_port_off;
    (!st_r.portSel && !dedSet && !st_r.latch) |=> !st_r.latch;
  endproperty
  a_port_off: assert property (p_port_off) else $error("unselected port requested");

  property p_wake_enable;
    (lowPower && !takeNow) |=> (st_r.enable && !st_r.mask);
  endproperty
  a_wake_enable: assert property (p_wake_enable) else $error("low power entry wrong");

  property p_pin_level;
    1'b1 |-> ##2 (st_r.cpu.pinLevel == $past(irqPin_n, 3));
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level tracks wrong source");

  property p_pend_read;
    (rdFire && rdSel == SEL_SC) |=> (st_r.axi.rdata[3] == $past(st_r.latch)
      && st_r.axi.rdata[6:4] == 3'h0 && st_r.axi.rdata[2:0] == 3'h0);
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("status read wrong");

  c_service: cover property (st_r.cpu.intStart ##2 st_r.phase == PH_IDLE);
  c_port_req: cover property (portSet && !dedSet);
  c_sw_clear: cover property (clrHit ##1 !st_r.latch);
  c_disabled_pend: cover property (st_r.latch && !st_r.enable && cpuCtl.instrEnd);

endmodule

// *** rtl/ext_int_defines.svh ***
// Purpose: Offsets, bit positions, reset values and vector addresses of the external interrupt latch
// Assumes: Included by its bare name wherever the constants are needed
// Notes:   Definitions only
`ifndef EXT_INT_DEFINES_SVH
`define EXT_INT_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define EXT_INT_SC_OFFSET   8'h00
`define EXT_INT_OPT_OFFSET  8'h04

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define EXT_INT_CLR_BIT     1
`define EXT_INT_PEND_BIT    3
`define EXT_INT_EN_BIT      7
`define EXT_INT_PSEL_BIT    0
`define EXT_INT_LVL_BIT     1

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EXT_INT_EN_RST      1'b1
`define EXT_INT_PEND_RST    1'b0
`define EXT_INT_MASK_RST    1'b1
`define EXT_INT_PSEL_RST    1'b0
`define EXT_INT_LVL_RST     1'b0
`define EXT_INT_IRQ_IDLE    1'b1
`define EXT_INT_PORT_IDLE   4'h0

// ----------------------------------------------------------------------
// Vector addresses and bus responses
// ----------------------------------------------------------------------
`define EXT_INT_VEC_HI      16'h07fa
`define EXT_INT_VEC_LO      16'h07fb
`define EXT_INT_RESP_OKAY   2'h0
`define EXT_INT_RESP_SLVERR 2'h2

`endif

// *** rtl/ext_int_pkg.sv ***
// Purpose: Types shared by the external interrupt latch and its bench
// Assumes: Nothing beyond the defines header
// Notes:   Bus carriers follow AXI4-Lite signal names
package ext_int_pkg;

  // ----------------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE   = 2'b00,
    PH_VEC_HI = 2'b01,
    PH_VEC_LO = 2'b10
  } phase_t;

  typedef enum logic [1:0] {
    SEL_SC   = 2'b00,
    SEL_OPT  = 2'b01,
    SEL_NONE = 2'b10
  } reg_sel_t;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axi_lite_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_lite_rsp_t;

  typedef struct packed {
    logic instrEnd;
    logic setMask;
    logic clearMask;
    logic stopExec;
    logic waitExec;
  } cpu_ctl_t;

  typedef struct packed {
    logic        intStart;
    logic        vecFetch;
    logic [15:0] vecAddr;
    logic        maskBit;
    logic        pinLevel;
  } cpu_int_t;

  // ----------------------------------------------------------------------
  // Whole state of the latch
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic          irqMeta;
    logic          irqSync;
    logic          irqPrev;
    logic [3:0]    portMeta;
    logic [3:0]    portSync;
    logic [3:0]    portPrev;
    logic          latch;
    logic          enable;
    logic          mask;
    logic          portSel;
    logic          levelSense;
    phase_t        phase;
    cpu_int_t      cpu;
    axi_lite_rsp_t axi;
  } state_t;

endpackage

// *** test/cpu_core_model.sv ***
// Purpose: Core stand-in that paces instruction ends and checks vector fetches
// Assumes: Bench pulses mask, stop and wait commands one cycle each
// Notes:   PERIOD sets the cadence; a long one models a slow core
`timescale 1ns/1ns
`include "ext_int_defines.svh"
module cpu_core_model
  import ext_int_pkg::*;
#(
  parameter int PERIOD = 4
)(
  input  wire logic     clock,
  input  wire logic     rst_n,
  input  wire logic     run,
  input  wire cpu_ctl_t cmd,
  input  wire cpu_int_t cpuInt,
  output cpu_ctl_t      cpuCtl,
  output int            takenCount,
  output int            vecErrors
);
  int   pace;
  logic hiDone;

  // ----------------------------------------------------------------------
  // Instruction pacing
  // ----------------------------------------------------------------------
  // One sample point per instruction; commands pass through registered
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pace   <= 0;
      cpuCtl <= '0;
    end else begin
      pace   <= (pace >= PERIOD - 1) ? 0 : pace + 1;
      cpuCtl <= cmd | {run && pace == 0, 4'h0};
    end
  end

  // Vector bytes must arrive high byte first, each on its own cycle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hiDone     <= 1'b0;
      takenCount <= 0;
      vecErrors  <= 0;
    end else begin
      if (cpuInt.intStart === 1'b1) begin
        takenCount <= takenCount + 1;
      end
      if (cpuInt.vecFetch === 1'b1) begin
        hiDone <= !hiDone;
        if (cpuInt.vecAddr !== (hiDone ? `EXT_INT_VEC_LO : `EXT_INT_VEC_HI)) begin
          vecErrors <= vecErrors + 1;
        end
      end
    end
  end
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the external interrupt latch
// Assumes: Register access over AXI4-Lite, pins driven by the bench
// Notes:   Pin effects are read back after fixed synchroniser delays
`timescale 1ns/1ns
`include "ext_int_defines.svh"
module testbench
  import ext_int_pkg::*;
;
  localparam logic [7:0] EN = 8'h01 << `EXT_INT_EN_BIT;
  localparam logic [7:0] PD = 8'h01 << `EXT_INT_PEND_BIT;
  localparam logic [7:0] CL = 8'h01 << `EXT_INT_CLR_BIT;
  localparam logic [7:0] PS = 8'h01 << `EXT_INT_PSEL_BIT;
  localparam logic [7:0] LV = 8'h01 << `EXT_INT_LVL_BIT;
  localparam logic [7:0] SC = `EXT_INT_SC_OFFSET;
  localparam logic [7:0] OP = `EXT_INT_OPT_OFFSET;
  localparam cpu_ctl_t   CLI = 5'h04;
  localparam cpu_ctl_t   SEI = 5'h08;

  logic          clock       = 1'b0;
  logic          rst_n       = 1'b0;
  logic          run         = 1'b0;
  logic          irqPin_n    = 1'b1;
  logic [3:0]    portIntPins = 4'h0;
  axi_lite_req_t req         = '0;
  axi_lite_rsp_t rsp;
  cpu_ctl_t      cmd         = '0;
  cpu_ctl_t      cpuCtl;
  cpu_int_t      cpuInt;
  int            takenCount;
  int            vecErrors;
  int            fails       = 0;
  int            n_checks    = 0;

  // Clock and units under test
  always #20 clock = ~clock;

  external_interrupt_latch external_interrupt_latch_inst (
    .clock(clock), .rst_n(rst_n), .axiReq(req), .axiRsp(rsp), .cpuCtl(cpuCtl),
    .cpuInt(cpuInt), .irqPin_n(irqPin_n), .portIntPins(portIntPins));

  cpu_core_model #(.PERIOD(3)) cpu_core_model_inst (
    .clock(clock), .rst_n(rst_n), .run(run), .cmd(cmd), .cpuInt(cpuInt),
    .cpuCtl(cpuCtl), .takenCount(takenCount), .vecErrors(vecErrors));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  // Bounded wait step; a stuck handshake ends the run
  task automatic tick(inout int n);
    @(posedge clock);
    n++;
    if (n > 40) begin
      fails++;
      final_report();
    end
  endtask

  task automatic cycles(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic endTest(input string s);
    $display("test %s done", s);
  endtask

  task automatic setPins(input logic i, input logic [3:0] p);
    @(posedge clock);
    irqPin_n    <= i;
    portIntPins <= p;
  endtask

  task automatic pulse(input cpu_ctl_t c);
    @(posedge clock);
    cmd <= c;
    @(posedge clock);
    cmd <= '0;
  endtask

  // Address and data offered together, each released at its own ready edge
  task automatic axiWrite(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int   n;
    logic awOpen;
    logic wOpen;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr  <= {24'h0, a};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    n      = 0;
    awOpen = 1'b1;
    wOpen  = 1'b1;
    // The slave may take either channel first, so each is watched alone
    do begin
      tick(n);
      if (awOpen && rsp.awready === 1'b1) begin
        req.awvalid <= 1'b0;
        awOpen = 1'b0;
      end
      if (wOpen && rsp.wready === 1'b1) begin
        req.wvalid <= 1'b0;
        wOpen = 1'b0;
      end
    end while (awOpen || wOpen);
    do tick(n); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check(rsp.bresp, er, "write response");
  endtask

  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr  <= {24'h0, a};
    req.rready  <= 1'b1;
    n = 0;
    do tick(n); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do tick(n); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axiRead(a, d, r);
    check(d, e, "register read");
    check(r, `EXT_INT_RESP_OKAY, "read response");
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    cycles(3);
    rdChk(SC, EN);
    rdChk(OP, 0);
    check(cpuInt.maskBit, 1'b1, "mask after reset");
    axiRead(8'h08, d, r);
    check(d, 32'h0, "unmapped read data");
    check(r, `EXT_INT_RESP_SLVERR, "unmapped read response");
    axiWrite(8'h08, 8'hff, `EXT_INT_RESP_SLVERR);
    endTest("reset");
    // Edge only on the dedicated pin; a held low level must not re-arm
    setPins(0, 0);
    cycles(5);
    rdChk(SC, EN | PD);
    check(cpuInt.pinLevel, 1'b0, "pin level");
    axiWrite(SC, EN, `EXT_INT_RESP_OKAY);
    rdChk(SC, EN | PD);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    rdChk(SC, EN);
    setPins(1, 0);
    cycles(5);
    rdChk(SC, EN);
    setPins(0, 0);
    cycles(5);
    rdChk(SC, EN | PD);
    setPins(1, 0);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    endTest("edge");
    // Level mode keeps the request while the pin stays low
    axiWrite(OP, LV, `EXT_INT_RESP_OKAY);
    rdChk(OP, LV);
    setPins(0, 0);
    cycles(5);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    rdChk(SC, EN | PD);
    setPins(1, 4'h1);
    cycles(5);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    rdChk(SC, EN);
    // Port pins must idle low before the group is selected, or no edge is seen
    setPins(1, 0);
    endTest("level");
    // Port group in edge mode, each pin on its own, then level mode on the top pin
    axiWrite(OP, PS, `EXT_INT_RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      setPins(1, 4'h1 << i);
      cycles(5);
      rdChk(SC, EN | PD);
      check(cpuInt.pinLevel, 1'b1, "pin level");
      axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
      rdChk(SC, EN);
      setPins(1, 0);
      cycles(3);
    end
    axiWrite(OP, PS | LV, `EXT_INT_RESP_OKAY);
    setPins(1, 4'h8);
    cycles(5);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    rdChk(SC, EN | PD);
    setPins(1, 0);
    cycles(5);
    axiWrite(SC, EN | CL, `EXT_INT_RESP_OKAY);
    axiWrite(OP, 0, `EXT_INT_RESP_OKAY);
    endTest("ports");
    // Service: held off while disabled, taken once enabled, retaken after return
    axiWrite(SC, 0, `EXT_INT_RESP_OKAY);
    run <= 1'b1;
    pulse(CLI);
    setPins(0, 0);
    cycles(12);
    check(takenCount, 0, "taken while disabled");
    rdChk(SC, PD);
    axiWrite(SC, EN, `EXT_INT_RESP_OKAY);
    cycles(12);
    check(takenCount, 1, "taken once enabled");
    check(cpuInt.maskBit, 1'b1, "mask in service");
    rdChk(SC, EN);
    setPins(1, 0);
    cycles(4);
    setPins(0, 0);
    cycles(12);
    check(takenCount, 1, "taken while masked");
    rdChk(SC, EN | PD);
    pulse(CLI);
    cycles(12);
    check(takenCount, 2, "taken after return");
    check(vecErrors, 0, "vector addresses");
    run <= 1'b0;
    setPins(1, 0);
    endTest("service");
    // Stop and wait re-enable and unmask
    for (int k = 0; k < 2; k++) begin
      axiWrite(SC, CL, `EXT_INT_RESP_OKAY);
      pulse(SEI);
      pulse(cpu_ctl_t'(k ? 5'h01 : 5'h02));
      cycles(2);
      rdChk(SC, EN);
      check(cpuInt.maskBit, 1'b0, "mask after low power");
    end
    endTest("lowpower");
    final_report();
  end
endmodule
